/* File: logic/motor_startup_supervision.sv */
`timescale 1ns/10ps
// Overview of operation
// - Rise out of idle launches the startup timer.
// - Starting output while startup timer runs.
// - Running output while current above idle limit.
// - Expiry above startup limit flags prolonged start.
// - Startup expiry launches restart inhibition timer.
// - Aborted start also launches restart inhibition.
// - Count up to 5 starts per hour; zero disables.
// - Flag when one permitted restart remains.
// - Inhibit after last start until oldest ages.
// - Operation off keeps every output low.
// - Limits scale with motor rating percentage.
// - Startup limit in percent of rating.
// - Idle limit in percent of rating.
// - Compare fundamental magnitudes from front end.
// - Blocking input disables the function.
module motor_startup_supervision #(
  parameter int unsigned CYC_PER_SEC = mss_pkg::CYC_PER_SEC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mss_pkg::cur_t cur_l1,
  input wire mss_pkg::cur_t cur_l2,
  input wire mss_pkg::cur_t cur_l3,
  input wire logic function_block_in,
  output logic motor_starting_out,
  output logic motor_running_out,
  output logic prolonged_start_out,
  output logic restart_inhibited_out,
  output logic last_restart_left_out
);
  import mss_pkg::*;

  hist_if h();
  logic tick;
  logic tick_clr;
  logic blk_meta_q, blk_q;
  logic op_q, op_d;
  logic [7:0] rating_q, rating_d;
  logic [9:0] start_pct_q, start_pct_d;
  logic [5:0] idle_pct_q, idle_pct_d;
  logic [6:0] su_s_q, su_s_d;
  logic [12:0] rs_s_q, rs_s_d;
  logic [2:0] permit_q, permit_d;
  logic [31:0] rdata_q, rdata_d;
  logic hit;
  phase_t st_q, st_d;
  logic [6:0] su_cnt_q, su_cnt_d;
  logic [12:0] rs_cnt_q, rs_cnt_d;
  logic long_q, long_d;
  logic was_high_q, was_high_d;
  logic [4:0] out_q, out_d;
  cur_t imax;
  logic act, hi_idle, hi_start, detect, abort, expire, limit_hit, last_one;

  sec_tick #(.CYC(CYC_PER_SEC)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clear(tick_clr),
    .tick(tick)
  );

  start_history u_hist (
    .pclk(pclk),
    .presetn(presetn),
    .h(h)
  );

  // The blocking input comes from another logic domain and is synchronised first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blk_meta_q <= 1'b0;
      blk_q <= 1'b0;
    end
    else
    begin
      blk_meta_q <= function_block_in;
      blk_q <= blk_meta_q;
    end
  end

  // Address decode; every access completes with no wait state.
  always_comb
  begin
    unique case (paddr[7:0])
      OFS_CTRL, OFS_RATING, OFS_START_PCT, OFS_IDLE_PCT, OFS_STARTUP_S, OFS_RESTART_S,
      OFS_PERMIT: hit = paddr[31:8] == 24'h0;
      OFS_STATUS, OFS_COUNT: hit = paddr[31:8] == 24'h0 && !pwrite;
      default: hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = rdata_q;

  // Settings take effect at the access edge; read data is captured in the setup cycle.
  always_comb
  begin
    op_d = op_q;
    rating_d = rating_q;
    start_pct_d = start_pct_q;
    idle_pct_d = idle_pct_q;
    su_s_d = su_s_q;
    rs_s_d = rs_s_q;
    permit_d = permit_q;
    rdata_d = rdata_q;
    if (psel && penable && pwrite && hit)
    begin
      unique case (paddr[7:0])
        OFS_CTRL: op_d = pwdata[0];
        OFS_RATING: rating_d = pwdata[7:0];
        OFS_START_PCT: start_pct_d = pwdata[9:0];
        OFS_IDLE_PCT: idle_pct_d = pwdata[5:0];
        OFS_STARTUP_S: su_s_d = pwdata[6:0];
        OFS_RESTART_S: rs_s_d = pwdata[12:0];
        OFS_PERMIT: permit_d = pwdata[2:0];
        default: op_d = op_q;
      endcase
    end
    if (psel && !penable)
    begin
      unique case (paddr[7:0])
        OFS_CTRL: rdata_d = {31'h0, op_q};
        OFS_RATING: rdata_d = {24'h0, rating_q};
        OFS_START_PCT: rdata_d = {22'h0, start_pct_q};
        OFS_IDLE_PCT: rdata_d = {26'h0, idle_pct_q};
        OFS_STARTUP_S: rdata_d = {25'h0, su_s_q};
        OFS_RESTART_S: rdata_d = {19'h0, rs_s_q};
        OFS_PERMIT: rdata_d = {29'h0, permit_q};
        OFS_STATUS: rdata_d = {25'h0, st_q, out_q};
        OFS_COUNT: rdata_d = {29'h0, h.count};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_q <= RST_OPERATION;
      rating_q <= RST_RATING;
      start_pct_q <= RST_START_PCT;
      idle_pct_q <= RST_IDLE_PCT;
      su_s_q <= RST_STARTUP_S;
      rs_s_q <= RST_RESTART_S;
      permit_q <= RST_PERMIT;
      rdata_q <= 32'h0;
    end
    else
    begin
      op_q <= op_d;
      rating_q <= rating_d;
      start_pct_q <= start_pct_d;
      idle_pct_q <= idle_pct_d;
      su_s_q <= su_s_d;
      rs_s_q <= rs_s_d;
      permit_q <= permit_d;
      rdata_q <= rdata_d;
    end
  end

  // Level detection on the largest fundamental magnitude of the three phases.
  always_comb
  begin
    imax = cur_l1;
    if (cur_l2 > imax)
      imax = cur_l2;
    if (cur_l3 > imax)
      imax = cur_l3;
  end

  assign act = op_q && !blk_q;
  assign hi_idle = over_limit(imax, rating_q, {4'h0, idle_pct_q});
  assign hi_start = over_limit(imax, rating_q, start_pct_q);
  assign detect = act && st_q == st_idle && hi_idle && !was_high_q;
  assign abort = act && st_q == st_start && !hi_idle;
  assign expire = act && st_q == st_start && hi_idle && tick && su_cnt_q <= 7'h1;
  assign limit_hit = permit_q != 3'h0 && h.count >= permit_q;
  assign last_one = permit_q != 3'h0 && h.count == permit_q - 3'h1;
  assign tick_clr = detect || abort;
  assign h.push = detect;
  assign h.tick = tick;
  assign h.flush = !act;

  // Startup sequencing, the two second-based timers and the memory of a high current.
  // A start needs a rise from below idle, so enabling under load is not taken as a start.
  always_comb
  begin
    was_high_d = hi_idle || !act;
    st_d = st_q;
    su_cnt_d = su_cnt_q;
    rs_cnt_d = rs_cnt_q;
    long_d = long_q;
    if (tick && rs_cnt_q != 13'h0)
      rs_cnt_d = rs_cnt_q - 13'h1;
    unique case (st_q)
      st_idle:
        if (detect)
        begin
          st_d = st_start;
          su_cnt_d = su_s_q;
          long_d = 1'b0;
        end
      st_start:
        if (abort)
        begin
          st_d = st_idle;
          rs_cnt_d = rs_s_q;
        end
        else if (expire)
        begin
          st_d = st_done;
          su_cnt_d = 7'h0;
          rs_cnt_d = rs_s_q;
          long_d = hi_start;
        end
        else if (tick)
          su_cnt_d = su_cnt_q - 7'h1;
      st_done:
        if (!hi_idle)
        begin
          st_d = st_idle;
          long_d = 1'b0;
        end
    endcase
    if (!act)
    begin
      st_d = st_idle;
      su_cnt_d = 7'h0;
      rs_cnt_d = 13'h0;
      long_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= st_idle;
      su_cnt_q <= 7'h0;
      rs_cnt_q <= 13'h0;
      long_q <= 1'b0;
      was_high_q <= 1'b1;
    end
    else
    begin
      was_high_q <= was_high_d;
      st_q <= st_d;
      su_cnt_q <= su_cnt_d;
      rs_cnt_q <= rs_cnt_d;
      long_q <= long_d;
    end
  end

  // Outputs come from flip-flops; all are forced low while the function is off or blocked.
  always_comb
  begin
    out_d = 5'h0;
    if (act)
    begin
      out_d[0] = st_q == st_start;
      out_d[1] = hi_idle;
      out_d[2] = long_q;
      out_d[3] = rs_cnt_q != 13'h0 || limit_hit;
      out_d[4] = last_one;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_q <= 5'h0;
    else
      out_q <= out_d;
  end

  assign motor_starting_out = out_q[0];
  assign motor_running_out = out_q[1];
  assign prolonged_start_out = out_q[2];
  assign restart_inhibited_out = out_q[3];
  assign last_restart_left_out = out_q[4];

  // Checks on the observable behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_detect: assert property (detect |=> st_q == st_start
    ##1 (motor_starting_out || !$past(act)))
    else $error("start not detected");
  a_start_length: assert property (expire |=> st_q == st_done ##1 !motor_starting_out)
    else $error("startup timer did not end");
  a_running_flag: assert property (act && hi_idle |=> motor_running_out)
    else $error("running flag missing");
  a_long_start: assert property (expire && hi_start && act |=>
    ##1 (prolonged_start_out || !$past(act)))
    else $error("prolonged start not flagged");
  a_restart_timer: assert property (expire |=> rs_cnt_q == $past(rs_s_q)
    ##1 (restart_inhibited_out || !$past(act)))
    else $error("restart timer not launched");
  a_abort_inhibit: assert property (abort && rs_s_q != 13'h0 |=> rs_cnt_q != 13'h0
    ##1 (restart_inhibited_out || !$past(act)))
    else $error("abort did not inhibit restart");
  a_last_left: assert property (act && last_one |=> last_restart_left_out)
    else $error("last restart flag missing");
  a_limit_inhibit: assert property (act && limit_hit |=> restart_inhibited_out)
    else $error("start limit did not inhibit");
  a_off_quiet: assert property (!act |=> out_q == 5'h0)
    else $error("output active while disabled");

  c_good_start: cover property (detect ##[1:1000] (expire && !hi_start));
  c_long_start: cover property (expire && hi_start);
  c_abort: cover property (abort);
  c_limit: cover property (act && limit_hit);
endmodule // motor_startup_supervision

/* File: logic/mss_pkg.sv */
package mss_pkg;
  // Clock and time base.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SEC_NS = 1_000_000_000;
  localparam int unsigned CYC_PER_SEC_DEF = SEC_NS / CLK_PERIOD_NS;
  localparam logic [12:0] HOUR_S = 13'h0e10;
  localparam int unsigned MAX_SLOTS = 5;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATING = 8'h04;
  localparam logic [7:0] OFS_START_PCT = 8'h08;
  localparam logic [7:0] OFS_IDLE_PCT = 8'h0c;
  localparam logic [7:0] OFS_STARTUP_S = 8'h10;
  localparam logic [7:0] OFS_RESTART_S = 8'h14;
  localparam logic [7:0] OFS_PERMIT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_COUNT = 8'h20;

  // Values after reset.
  localparam logic RST_OPERATION = 1'b0;
  localparam logic [7:0] RST_RATING = 8'h64;
  localparam logic [9:0] RST_START_PCT = 10'h0c8;
  localparam logic [5:0] RST_IDLE_PCT = 6'h0a;
  localparam logic [6:0] RST_STARTUP_S = 7'h05;
  localparam logic [12:0] RST_RESTART_S = 13'h0014;
  localparam logic [2:0] RST_PERMIT = 3'h0;

  // Phase current magnitude in the same units as the motor rating.
  typedef logic [15:0] cur_t;
  typedef enum logic [1:0] {st_idle, st_start, st_done} phase_t;

  // True when the current is above pct percent of the motor rating.
  function automatic logic over_limit(input cur_t cur, input logic [7:0] rating,
                                      input logic [9:0] pct);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(cur) * 24'h000064;
    rhs = 24'(rating) * 24'(pct);
    return lhs > rhs;
  endfunction
endpackage

/* File: logic/hist_if.sv */
`timescale 1ns/10ps
interface hist_if;
  logic push;
  logic tick;
  logic flush;
  logic [2:0] count;
  modport ctrl (output push, output tick, output flush, input count);
  modport store (input push, input tick, input flush, output count);
endinterface

/* File: logic/sec_tick.sv */
`timescale 1ns/10ps
module sec_tick #(
  parameter int unsigned CYC = mss_pkg::CYC_PER_SEC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  output logic tick
);
  import mss_pkg::*;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic wrap;

  // The divider restarts on clear so that a timer launched now sees a whole first second.
  always_comb
  begin
    wrap = cnt_q == 32'(CYC - 1);
    cnt_d = (clear || wrap) ? 32'h0 : cnt_q + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_d;
  end

  assign tick = wrap && !clear;
endmodule // sec_tick

/* File: logic/start_history.sv */
`timescale 1ns/10ps
module start_history (
  input wire logic pclk,
  input wire logic presetn,
  hist_if.store h
);
  import mss_pkg::*;
  logic [12:0] now_q, now_d;
  logic [12:0] ts_q [MAX_SLOTS];
  logic [12:0] ts_d [MAX_SLOTS];
  logic [MAX_SLOTS-1:0] vld_q, vld_d;
  logic [2:0] cnt_q, cnt_d;

  // Each start is stamped with the seconds clock and leaves after an hour.
  always_comb
  begin
    logic placed;
    logic [12:0] age;
    placed = 1'b0;
    age = 13'h0;
    now_d = h.tick ? now_q + 13'h1 : now_q;
    vld_d = vld_q;
    ts_d = ts_q;
    cnt_d = 3'h0;
    for (int i = 0; i < MAX_SLOTS; i++)
    begin
      age = now_q - ts_q[i];
      if (age >= HOUR_S)
        vld_d[i] = 1'b0;
      if (h.push && !placed && !vld_d[i])
      begin
        vld_d[i] = 1'b1;
        ts_d[i] = now_q;
        placed = 1'b1;
      end
      if (h.flush)
        vld_d[i] = 1'b0;
      cnt_d = cnt_d + 3'(vld_d[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      now_q <= 13'h0;
      vld_q <= '0;
      cnt_q <= 3'h0;
      for (int i = 0; i < MAX_SLOTS; i++)
        ts_q[i] <= 13'h0;
    end
    else
    begin
      now_q <= now_d;
      vld_q <= vld_d;
      cnt_q <= cnt_d;
      ts_q <= ts_d;
    end
  end

  assign h.count = cnt_q;
endmodule // start_history

/* File: verification/phase_front_end.sv */
`timescale 1ns/10ps
// Stand-in for the measurement stage and the user logic that drives blocking.
module phase_front_end
  import mss_pkg::*;
(
  input wire logic pclk,
  output cur_t cur_l1,
  output cur_t cur_l2,
  output cur_t cur_l3,
  output logic block
);
  cur_t nxt [3];
  logic blk_nxt;

  // New values reach the pins only at a rising edge, like a sampled magnitude stream.
  always_ff @(posedge pclk)
  begin
    cur_l1 <= nxt[0];
    cur_l2 <= nxt[1];
    cur_l3 <= nxt[2];
    block <= blk_nxt;
  end

  // Requests land by non-blocking assignment so the edge that follows a call never races it.
  task automatic set_cur(input cur_t a, input cur_t b, input cur_t c);
    nxt[0] <= a;
    nxt[1] <= b;
    nxt[2] <= c;
  endtask

  task automatic set_block(input logic v);
    blk_nxt <= v;
  endtask

  // Everything starts at a stopped motor with blocking released.
  initial
  begin
    nxt = '{16'h0000, 16'h0000, 16'h0000};
    blk_nxt = 1'b0;
  end
endmodule // phase_front_end

/* File: verification/motor_startup_supervision_tb_top.sv */
`timescale 1ns/10ps
module motor_startup_supervision_tb_top;
  import mss_pkg::*;
  localparam int ST = 0, RN = 1, LG = 2, IH = 3, LS = 4;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, blk, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  cur_t c1, c2, c3;
  wire [4:0] outs;
  int fail_count, checked, waited;
  // Reset values, refused accesses and field masking, one access per row.
  row_t rows [14] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h04, 0, 32'h64, 0}, '{0, 8'h08, 0, 32'hc8, 0},
    '{0, 8'h0c, 0, 32'h0a, 0}, '{0, 8'h10, 0, 32'h05, 0}, '{0, 8'h14, 0, 32'h14, 0},
    '{0, 8'h18, 0, 0, 0}, '{0, 8'h1c, 0, 0, 0}, '{0, 8'h20, 0, 0, 0}, '{0, 8'h24, 0, 0, 1},
    '{1, 8'h1c, 32'h7f, 0, 1}, '{1, 8'h0c, 32'hff, 0, 0}, '{0, 8'h0c, 0, 32'h3f, 0},
    '{1, 8'h0c, 32'h0a, 0, 0}};

  motor_startup_supervision #(.CYC_PER_SEC(4)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cur_l1(c1), .cur_l2(c2),
    .cur_l3(c3), .function_block_in(blk), .motor_starting_out(outs[0]),
    .motor_running_out(outs[1]), .prolonged_start_out(outs[2]),
    .restart_inhibited_out(outs[3]), .last_restart_left_out(outs[4]));
  phase_front_end fe (.pclk(pclk), .cur_l1(c1), .cur_l2(c2), .cur_l3(c3), .block(blk));

  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits on one output with a bound, so a stuck design is reported instead of hanging.
  task automatic expect_bit(input int i, input logic v, input int lim);
    waited = 0;
    while (outs[i] !== v && waited < lim)
    begin
      @(posedge pclk);
      waited++;
    end
    check(32'(outs[i]), 32'(v));
  endtask

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence: table first, then the timed motor scenarios.
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    cyc(2);
    presetn <= 1'b1;
    foreach (rows[k])
    begin
      apb(rows[k].w, rows[k].a, rows[k].d);
      if (!rows[k].w)
        check(rd, rows[k].q);
      check(32'(er), 32'(rows[k].e));
    end
    $display("test registers done");
    fe.set_cur(16'h0032, 16'h0000, 16'h0000);
    cyc(6);
    check(32'(outs), 32'h0);
    fe.set_cur(16'h0000, 16'h0000, 16'h0000);
    apb(1'b1, 8'h00, 32'h1);
    cyc(4);
    fe.set_cur(16'h000a, 16'h0009, 16'h0008);
    cyc(6);
    check(32'(outs), 32'h0);
    fe.set_cur(16'h000a, 16'h000b, 16'h0009);
    expect_bit(RN, 1'b1, 5);
    expect_bit(ST, 1'b1, 5);
    expect_bit(ST, 1'b0, 40);
    check(32'(waited >= 18 && waited <= 22), 32'h1);
    check(32'(outs[4:2]), 32'h2);
    fe.set_cur(16'h0000, 16'h0000, 16'h0000);
    expect_bit(IH, 1'b0, 100);
    check(32'(waited >= 70), 32'h1);
    $display("test normal start done");
    fe.set_cur(16'h0000, 16'h0000, 16'h00fa);
    expect_bit(ST, 1'b1, 5);
    expect_bit(ST, 1'b0, 40);
    check(32'(outs[LG]), 32'h1);
    fe.set_cur(16'h0000, 16'h0000, 16'h0000);
    expect_bit(LG, 1'b0, 5);
    expect_bit(IH, 1'b0, 100);
    $display("test long start done");
    fe.set_cur(16'h0032, 16'h0000, 16'h0000);
    expect_bit(ST, 1'b1, 5);
    cyc(5);
    fe.set_cur(16'h0000, 16'h0000, 16'h0000);
    expect_bit(IH, 1'b1, 5);
    expect_bit(ST, 1'b0, 5);
    expect_bit(IH, 1'b0, 100);
    apb(1'b1, 8'h04, 32'h32);
    fe.set_cur(16'h0006, 16'h0000, 16'h0000);
    expect_bit(RN, 1'b1, 5);
    fe.set_cur(16'h0000, 16'h0000, 16'h0000);
    apb(1'b1, 8'h04, 32'h64);
    fe.set_cur(16'h0032, 16'h0000, 16'h0000);
    expect_bit(RN, 1'b1, 5);
    fe.set_block(1'b1);
    expect_bit(RN, 1'b0, 8);
    check(32'(outs), 32'h0);
    fe.set_block(1'b0);
    fe.set_cur(16'h0000, 16'h0000, 16'h0000);
    $display("test abort scale block done");
    apb(1'b1, 8'h18, 32'h2);
    fe.set_cur(16'h0032, 16'h0000, 16'h0000);
    expect_bit(LS, 1'b1, 8);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h1);
    fe.set_cur(16'h0000, 16'h0000, 16'h0000);
    expect_bit(RN, 1'b0, 5);
    fe.set_cur(16'h0032, 16'h0000, 16'h0000);
    expect_bit(LS, 1'b0, 8);
    check(32'(outs[IH]), 32'h1);
    fe.set_cur(16'h0000, 16'h0000, 16'h0000);
    cyc(150);
    check(32'(outs[IH]), 32'h1);
    expect_bit(IH, 1'b0, 15000);
    check(32'(waited > 13000), 32'h1);
    check(32'(outs[LS]), 32'h1);
    expect_bit(LS, 1'b0, 40);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    $display("test hourly limit done");
    fe.set_cur(16'h0032, 16'h0000, 16'h0000);
    expect_bit(RN, 1'b1, 5);
    presetn <= 1'b0;
    cyc(2);
    check(32'(outs), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    check(32'(outs), 32'h0);
    $display("test reset done");
    end_of_test();
  end

  // Guard against a hang; the full run needs well under half of this span.
  initial
  begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end
endmodule // motor_startup_supervision_tb_top
